// File: hw/gpio_pin_four_output_mux.sv
// control register and output multiplexer for general pin four
module gpio_pin_four_output_mux
  import pin_four_pkg::*;
#(
  parameter int RX_PORTS = 4,
  parameter int TX_PORTS = 2
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [7:0]            reg_rdata,
  input  wire logic [4*RX_PORTS-1:0] rx_remote_pin,
  input  wire logic [RX_PORTS-1:0]   rx_lock,
  input  wire logic [RX_PORTS-1:0]   rx_pass,
  input  wire logic [RX_PORTS-1:0]   rx_frame_valid,
  input  wire logic [RX_PORTS-1:0]   rx_line_valid,
  input  wire logic [RX_PORTS-1:0]   rx_port_enabled,
  input  wire logic [RX_PORTS*TX_PORTS-1:0] tx_port_rx_map,
  input  wire logic [TX_PORTS-1:0]   tx_frame_valid,
  input  wire logic [TX_PORTS-1:0]   tx_line_valid,
  input  wire logic [TX_PORTS-1:0]   tx_synchronized,
  input  wire logic [TX_PORTS-1:0]   tx_interrupt,
  input  wire logic                  frame_sync_signal,
  output logic                       general_pin_four_out,
  output logic                       general_pin_four_oe
);
  `include "pin_four_defs.svh"

  // four remote pins plus lock, pass, frame and line valid per port
  localparam int RX_BITS = 8 * RX_PORTS;
  localparam int TX_BITS = 4 * TX_PORTS + 1;
  localparam int ALL_BITS = RX_BITS + TX_BITS;

  // all status inputs come from other logic or pins; sync them as one bundle
  logic [ALL_BITS-1:0] raw_bundle;
  logic [ALL_BITS-1:0] sync_bundle;
  assign raw_bundle = {rx_remote_pin, rx_lock, rx_pass, rx_frame_valid,
                       rx_line_valid, tx_frame_valid, tx_line_valid,
                       tx_synchronized, tx_interrupt, frame_sync_signal};

  pin_four_sync #(
    .WIDTH (ALL_BITS)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (raw_bundle),
    .sync_out (sync_bundle)
  );

  logic [4*RX_PORTS-1:0] s_remote;
  logic [RX_PORTS-1:0]   s_lock;
  logic [RX_PORTS-1:0]   s_pass;
  logic [RX_PORTS-1:0]   s_fv;
  logic [RX_PORTS-1:0]   s_lv;
  logic [TX_PORTS-1:0]   s_tx_fv;
  logic [TX_PORTS-1:0]   s_tx_lv;
  logic [TX_PORTS-1:0]   s_tx_sync;
  logic [TX_PORTS-1:0]   s_tx_irq;
  logic                  s_fsync;
  assign {s_remote, s_lock, s_pass, s_fv, s_lv, s_tx_fv, s_tx_lv,
          s_tx_sync, s_tx_irq, s_fsync} = sync_bundle;

  // register state
  logic [7:0] pin_four_output_control;
  logic [7:0] next_control;
  logic [7:0] next_rdata;

  always_comb begin
    next_control = pin_four_output_control;
    next_rdata   = 8'h00;
    if (reg_write && reg_addr == `PIN_FOUR_CTRL_ADDR) begin
      next_control = reg_wdata;
    end
    if (reg_read && reg_addr == `PIN_FOUR_CTRL_ADDR) begin
      next_rdata = pin_four_output_control;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_four_output_control <= `PIN_FOUR_CTRL_RESET;
      reg_rdata               <= 8'h00;
    end else begin
      pin_four_output_control <= next_control;
      reg_rdata               <= next_rdata;
    end
  end

  code_type pin_four_signal_select;
  code_type pin_four_source_select;
  logic     pin_four_register_level;
  logic     pin_four_drive_enable;
  assign pin_four_signal_select =
    pin_four_output_control[`PIN_FOUR_SEL_HI:`PIN_FOUR_SEL_LO];
  assign pin_four_source_select =
    pin_four_output_control[`PIN_FOUR_SRC_HI:`PIN_FOUR_SRC_LO];
  assign pin_four_register_level =
    pin_four_output_control[`PIN_FOUR_VAL_BIT];
  assign pin_four_drive_enable =
    pin_four_output_control[`PIN_FOUR_EN_BIT];

  source_class_type source_class;
  logic [1:0]       port_index;

  pin_four_decode u_decode (
    .source_code  (pin_four_source_select),
    .source_class (source_class),
    .port_index   (port_index)
  );

  // pass status of the receive ports that feed each transmit port
  logic [TX_PORTS-1:0] tx_pass_and;
  logic [TX_PORTS-1:0] tx_pass_or;
  genvar t;
  generate
    for (t = 0; t < TX_PORTS; t++) begin : g_tx_pass
      logic [RX_PORTS-1:0] member;
      assign member = tx_port_rx_map[t*RX_PORTS +: RX_PORTS];
      // an empty map gives AND low rather than vacuous high
      assign tx_pass_and[t] = (|member) && ((s_pass & member) == member);
      assign tx_pass_or[t]  = |(s_pass & member);
    end
  endgenerate

  logic any_enabled;
  logic lock_or;
  logic lock_and;
  logic pass_and;
  always_comb begin
    any_enabled = |rx_port_enabled;
    lock_or  = |(s_lock & rx_port_enabled);
    lock_and = any_enabled &&
               ((s_lock & rx_port_enabled) == rx_port_enabled);
    pass_and = any_enabled &&
               ((s_pass & rx_port_enabled) == rx_port_enabled);
  end

  logic pin_level;
  logic next_pin_out;
  logic next_pin_oe;

  always_comb begin
    pin_level = 1'b0;
    case (source_class)
      class_rx: begin
        case (pin_four_signal_select)
          3'h0, 3'h1, 3'h2, 3'h3:
            pin_level = s_remote[{port_index, pin_four_signal_select[1:0]}];
          3'h4: pin_level = s_lock[port_index];
          3'h5: pin_level = s_pass[port_index];
          3'h6: pin_level = s_fv[port_index];
          3'h7: pin_level = s_lv[port_index];
          default: pin_level = 1'b0;
        endcase
      end
      class_status: begin
        case (pin_four_signal_select)
          3'h0: pin_level = pin_four_register_level;
          3'h1: pin_level = lock_or;
          3'h2: pin_level = lock_and;
          3'h3: pin_level = pass_and;
          3'h4: pin_level = s_fsync;
          default: pin_level = 1'b0;
        endcase
      end
      class_tx: begin
        case (pin_four_signal_select)
          3'h0: pin_level = tx_pass_and[port_index[0]];
          3'h1: pin_level = tx_pass_or[port_index[0]];
          3'h2: pin_level = s_tx_fv[port_index[0]];
          3'h3: pin_level = s_tx_lv[port_index[0]];
          3'h4: pin_level = s_tx_sync[port_index[0]];
          3'h5: pin_level = s_tx_irq[port_index[0]];
          default: pin_level = 1'b0;
        endcase
      end
      default: pin_level = 1'b0;
    endcase
    // level held low while disabled so nothing leaks when enable returns
    next_pin_oe  = pin_four_drive_enable;
    next_pin_out = pin_four_drive_enable & pin_level;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      general_pin_four_out <= 1'b0;
      general_pin_four_oe  <= 1'b0;
    end else begin
      general_pin_four_out <= next_pin_out;
      general_pin_four_oe  <= next_pin_oe;
    end
  end
endmodule // gpio_pin_four_output_mux

// File: hw/pin_four_defs.svh
// register offset, field positions and reset value of the pin four control
`ifndef PIN_FOUR_DEFS_SVH
`define PIN_FOUR_DEFS_SVH
`define PIN_FOUR_CTRL_ADDR    8'h14
`define PIN_FOUR_CTRL_RESET   8'h00
`define PIN_FOUR_EN_BIT       0
`define PIN_FOUR_VAL_BIT      1
`define PIN_FOUR_SRC_LO       2
`define PIN_FOUR_SRC_HI       4
`define PIN_FOUR_SEL_LO       5
`define PIN_FOUR_SEL_HI       7
`define PIN_FOUR_SRC_RX_LAST  3'h3
`define PIN_FOUR_SRC_STATUS   3'h4
`define PIN_FOUR_SRC_RESV     3'h5
`define PIN_FOUR_SRC_TX0      3'h6
`define PIN_FOUR_SRC_TX1      3'h7
`endif

// File: hw/pin_four_pkg.sv
// types shared by the pin four output multiplexer
package pin_four_pkg;
  typedef enum logic [1:0] {
    class_rx,
    class_status,
    class_tx,
    class_none
  } source_class_type;
  typedef logic [2:0] code_type;
endpackage

// File: hw/pin_four_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
module pin_four_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage_one = async_in;
    next_sync_out  = stage_one;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync_out;
    end
  end
endmodule // pin_four_sync

// File: hw/pin_four_decode.sv
// maps the source field onto a source class and port index
module pin_four_decode
  import pin_four_pkg::*;
(
  input  wire pin_four_pkg::code_type        source_code,
  output pin_four_pkg::source_class_type     source_class,
  output logic                      [1:0]    port_index
);
  `include "pin_four_defs.svh"

  always_comb begin
    port_index = source_code[1:0];
    case (source_code)
      3'h0, 3'h1, 3'h2, `PIN_FOUR_SRC_RX_LAST: source_class = class_rx;
      `PIN_FOUR_SRC_STATUS: source_class = class_status;
      `PIN_FOUR_SRC_TX0: begin
        source_class = class_tx;
        port_index   = 2'h0;
      end
      `PIN_FOUR_SRC_TX1: begin
        source_class = class_tx;
        port_index   = 2'h1;
      end
      default: source_class = class_none;
    endcase
  end
endmodule // pin_four_decode

// File: tb/pin_four_monitor.sv
// timing checker for the pin four control register and pin outputs
module pin_four_monitor (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       general_pin_four_out,
  input wire logic       general_pin_four_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shadow;
  logic [7:0] next_shadow;
  logic       hit;
  logic       pin;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  assign hit = reg_addr == 8'h14;
  assign pin = general_pin_four_out;
  always_comb begin
    next_shadow = shadow;
    if (reg_write && hit) begin
      next_shadow = reg_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shadow <= 8'h00;
    end else begin
      shadow <= next_shadow;
    end
  end
  a_read_back: assert property (
    reg_read && hit |=> reg_rdata == $past(shadow))
    else $error("read data differs from control");
  a_unmapped_zero: assert property (
    reg_read && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_enable_follows: assert property (
    reg_write && hit |-> ##2
      general_pin_four_oe == $past(reg_wdata[0], 2))
    else $error("drive enable did not follow bit 0");
  a_off_low: assert property (
    !general_pin_four_oe |-> !pin)
    else $error("level high while not driving");
  a_level_bit: assert property (
    $past(shadow & 8'hfd) == 8'h11 |-> pin == $past(shadow[1]))
    else $error("register level not driven");
  a_resv_source: assert property (
    $past(shadow[4:2]) == 3'h5 |-> !pin)
    else $error("reserved source drove high");
  a_status_resv: assert property (
    $past(shadow[4:2]) == 3'h4 && $past(shadow[7:5]) >= 3'h5
      |-> !pin)
    else $error("reserved status select drove high");
  a_tx_resv: assert property (
    $past(shadow[4:3]) == 2'h3 && $past(shadow[7:6]) == 2'h3
      |-> !pin)
    else $error("reserved transmit select drove high");
endmodule // pin_four_monitor

bind gpio_pin_four_output_mux pin_four_monitor mon (
  .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .general_pin_four_out(general_pin_four_out),
  .general_pin_four_oe(general_pin_four_oe));

// File: tb/pin_four_far_side.sv
// board-side levels feeding the receive and transmit status inputs
module pin_four_far_side (
  input  wire logic        core_clk,
  input  wire logic [40:0] scene,
  output logic      [40:0] levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels move only after an edge, so the bench sees one extra cycle
  always_ff @(posedge core_clk) begin
    levels <= scene;
  end
endmodule // pin_four_far_side

// File: tb/gpio_pin_four_output_mux_tb.sv
// self-checking bench of the pin four output multiplexer
module gpio_pin_four_output_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic [3:0]  rx_port_enabled = 4'h3;
  logic [7:0]  tx_port_rx_map = 8'h96;
  logic [40:0] scene = {16'h8421, 16'h3684, 8'h66, 1'b1};
  logic [40:0] levels;
  logic        out;
  logic        oe;
  int          n_errors = 0;
  int          check_count = 0;
  // row: control byte, enabled ports, expected level
  logic [15:0] rows [] = '{16'h0131, 16'h2531, 16'h4931, 16'h6d31,
    16'h0d30, 16'h8131, 16'h8930, 16'ha531, 16'ha130, 16'hcd31,
    16'hc130, 16'he931, 16'he130, 16'h1331, 16'h1130, 16'h31c0,
    16'h3131, 16'h5131, 16'h5160, 16'h7161, 16'h7130, 16'h9131,
    16'hb330, 16'hd130, 16'hf130, 16'h1730, 16'h9530, 16'h1931,
    16'h1d30, 16'h3931, 16'h3d30, 16'h5931, 16'h5d30, 16'h7930,
    16'h7d31, 16'h9931, 16'h9d30, 16'hb930, 16'hbd31, 16'hdb30,
    16'hff30, 16'h1230};
  always #5 core_clk = ~core_clk;
  pin_four_far_side board (.core_clk(core_clk), .scene(scene),
    .levels(levels));
  gpio_pin_four_output_mux dut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_remote_pin(levels[40:25]),
    .rx_lock(levels[24:21]), .rx_pass(levels[20:17]),
    .rx_frame_valid(levels[16:13]), .rx_line_valid(levels[12:9]),
    .rx_port_enabled(rx_port_enabled), .tx_port_rx_map(tx_port_rx_map),
    .tx_frame_valid(levels[8:7]), .tx_line_valid(levels[6:5]),
    .tx_synchronized(levels[4:3]), .tx_interrupt(levels[2:1]),
    .frame_sync_signal(levels[0]), .general_pin_four_out(out),
    .general_pin_four_oe(oe));
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    cmp8(reg_rdata, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h14, 8'h00);
    cmp1(oe, 1'b0);
    foreach (rows[i]) begin
      @(posedge core_clk) rx_port_enabled <= rows[i][7:4];
      wr(8'h14, rows[i][15:8]);
      repeat (3) @(posedge core_clk);
      #1;
      cmp1(out, rows[i][0]);
      cmp1(oe, rows[i][8]);
      rd(8'h14, rows[i][15:8]);
    end
    // a lock drop must travel board flop, two sync stages and the pin flop
    wr(8'h14, 8'h81);
    @(posedge core_clk) scene[21] <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    cmp1(out, 1'b0);
    wr(8'h15, 8'hff);
    rd(8'h14, 8'h81);
    rd(8'h15, 8'h00);
    @(posedge core_clk) rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp1(oe, 1'b0);
    cmp1(out, 1'b0);
    @(posedge core_clk) rstn <= 1'b1;
    rd(8'h14, 8'h00);
    wrap_up();
  end
endmodule // gpio_pin_four_output_mux_tb
